//--- design/mcdec_core.sv
// Opcode decode, instruction-cycle sequencing and internal memory addressing.
// Assumes the core holds DEC_VALID_I until BUSY_O is low and owns the data path.
`timescale 1ns/1ps
module mcdec_core
	import mcdec_pkg::*;
(
	input  wire logic        CLK_I,
	input  wire logic        RST_I,
	input  wire logic        DEC_VALID_I,
	input  wire logic [7:0]  OPCODE_I,
	input  wire logic [15:0] PC_I,
	input  wire logic        SFR_WE_I,
	input  wire logic [7:0]  SFR_ADDR_I,
	input  wire logic [7:0]  SFR_WDATA_I,
	input  wire logic        IRAM_WE_I,
	input  wire logic [7:0]  IRAM_ADDR_I,
	input  wire logic [7:0]  IRAM_WDATA_I,
	input  wire logic        RES_REQ_I,
	input  wire logic [1:0]  RES_MODE_I,
	input  wire logic [7:0]  RES_ADDR_I,
	input  wire logic [15:0] XADDR_I,
	output logic             BUSY_O,
	output logic             DONE_O,
	output logic             ICYC_O,
	output logic [4:0]       DEC_CLASS_O,
	output logic [1:0]       DEC_BYTES_O,
	output logic [3:0]       DEC_CYCLES_O,
	output logic             DEC_KNOWN_O,
	output logic [7:0]       DEC_REG_ADDR_O,
	output logic [15:0]      OPND1_ADDR_O,
	output logic [15:0]      OPND2_ADDR_O,
	output logic [2:0]       STRETCH_O,
	output logic [1:0]       BANK_O,
	output logic             RES_VALID_O,
	output logic [1:0]       RES_SPACE_O,
	output logic [7:0]       RES_ADDR_O,
	output logic [2:0]       RES_BIT_O,
	output logic             RES_BITABLE_O,
	output logic             ONCHIP_O
);

	// ==========================================================
	// State
	// ==========================================================
	typedef struct packed {
		logic          busy;
		logic          done;
		logic          icyc;
		logic [1:0]    phase;
		logic [3:0]    left;
		mcdec_dec_t    dec;
		logic [7:0]    reg_addr;
		logic [15:0]   opnd1;
		logic [15:0]   opnd2;
		logic [2:0]    stretch;
		logic [1:0]    bank;
		mcdec_rstate_t rstate;
		logic          res_valid;
		mcdec_space_t  space;
		logic [7:0]    res_addr;
		logic [2:0]    res_bit;
		logic          bitable;
		logic          onchip;
	} mcdec_state_t;

	mcdec_state_t q;
	mcdec_state_t d;
	logic         accept;
	logic         rd_en;
	logic [7:0]   rd_addr;
	logic [7:0]   rd_data;

	// ==========================================================
	// Functions
	// ==========================================================
	function automatic logic [7:0] bank_reg(input logic [1:0] bank, input logic [2:0] n);
		bank_reg = {3'b000, bank, n};
	endfunction

	function automatic mcdec_dec_t decode(input logic [7:0] op, input logic [2:0] stretch);
		decode = '{cls: CLS_OTHER, bytes: 2'd1, cycles: 4'd1, known: 1'b0, ptr_op: 1'b0};
		decode.known = 1'b1;
		// Classes name the classic operations so the data path keeps their effects.
		if (op == OPC_NOP || op == OPC_RSVD_NOP)
		begin
			decode.cls = CLS_NO_OPERATION;
		end
		else if (op[7:3] == OPH_ADD_REG)
		begin
			decode.cls = CLS_ADD_REG;
		end
		else if (op[7:3] == OPH_ADD_WITH_CARRY_REG)
		begin
			decode.cls = CLS_ADD_WITH_CARRY;
		end
		else if (op[7:3] == OPH_SUBTRACT_WITH_BORROW_REG)
		begin
			decode.cls = CLS_SUB_WITH_BORROW;
		end
		else if (op == OPC_XDATA_RD_D || op == OPC_XDATA_WR_D
			|| op[7:1] == OPH_XDATA_RD_I || op[7:1] == OPH_XDATA_WR_I)
		begin
			decode.cls = CLS_EXT_DATA_MOVE;
			decode.cycles = XDATA_BASE_CYC + {1'b0, stretch};
		end
		else if (op == OPC_CODE_DATA_POINTER_REG || op == OPC_CODE_PC)
		begin
			decode.cls = CLS_CODE_BYTE_MOVE;
			decode.cycles = 4'd3;
		end
		else if (op == OPC_AND_DIR_IMM || op == OPC_OR_DIR_IMM || op == OPC_XOR_DIR_IMM)
		begin
			decode = '{cls: CLS_LOGIC_DIR_IMM, bytes: 2'd3, cycles: 4'd3,
				known: 1'b1, ptr_op: 1'b0};
		end
		else if (op == OPC_MOV_DIR_DIR)
		begin
			decode = '{cls: CLS_MOV_DIR_DIR, bytes: 2'd3, cycles: 4'd3,
				known: 1'b1, ptr_op: 1'b0};
		end
		else if (op == OPC_OR_C_BIT || op == OPC_OR_C_NBIT)
		begin
			decode.cls = (op == OPC_OR_C_BIT) ? CLS_OR_C_BIT : CLS_OR_C_NBIT;
			decode.bytes = 2'd2;
			decode.cycles = 4'd2;
		end
		else if (op == OPC_LONG_CALL)
		begin
			decode = '{cls: CLS_LONG_CALL, bytes: 2'd3, cycles: 4'd4,
				known: 1'b1, ptr_op: 1'b0};
		end
		else if (op == OPC_RETURN || op == OPC_INT_RETURN)
		begin
			decode.cls = (op == OPC_RETURN) ? CLS_RETURN : CLS_INT_RETURN;
			decode.cycles = 4'd4;
		end
		else if (op == OPC_JUMP_BIT_CLR)
		begin
			// The data path branches on a one and clears the bit.
			decode = '{cls: CLS_JUMP_BIT_CLEAR, bytes: 2'd3, cycles: 4'd4,
				known: 1'b1, ptr_op: 1'b0};
		end
		else if (op[7:3] == OPH_COMPARE_JUMP_UNEQUAL_REG)
		begin
			decode = '{cls: CLS_CMP_JUMP_UNEQ, bytes: 2'd3, cycles: 4'd4,
				known: 1'b1, ptr_op: 1'b0};
		end
		else if (op[7:3] == OPH_DECREMENT_JUMP_NONZERO_REG)
		begin
			decode = '{cls: CLS_DEC_JUMP_NZ, bytes: 2'd2, cycles: 4'd3,
				known: 1'b1, ptr_op: 1'b0};
		end
		else if (op == OPC_JMP_IND)
		begin
			decode.cls = CLS_JUMP_INDIRECT;
			decode.cycles = 4'd3;
		end
		else if (op[7:1] == OPH_EXCHANGE_LOW_NIBBLE)
		begin
			decode.cls = CLS_XCH_LOW_NIBBLE;
			decode.ptr_op = 1'b1;
		end
		else if (op == OPC_SHORT_JUMP)
		begin
			decode = '{cls: CLS_SHORT_JUMP, bytes: 2'd2, cycles: 4'd3,
				known: 1'b1, ptr_op: 1'b0};
		end
		else
		begin
			decode.known = 1'b0;
		end
		if (op[7:1] == OPH_XDATA_RD_I || op[7:1] == OPH_XDATA_WR_I)
		begin
			decode.ptr_op = 1'b1;
		end
	endfunction

	// ==========================================================
	// Internal RAM
	// ==========================================================
	mcdec_iram #(
		.WIDTH (8),
		.DEPTH (256)
	) u_iram (
		.clk_i   (CLK_I),
		.we_i    (IRAM_WE_I),
		.waddr_i (IRAM_ADDR_I),
		.wdata_i (IRAM_WDATA_I),
		.re_i    (rd_en),
		.raddr_i (rd_addr),
		.rdata_o (rd_data)
	);

	// ==========================================================
	// Next state
	// ==========================================================
	assign accept = DEC_VALID_I && !q.busy;

	always_comb
	begin
		d = q;
		d.done = 1'b0;
		d.icyc = 1'b0;
		d.res_valid = 1'b0;
		rd_en = 1'b0;
		// Pointer register of the active bank, chosen by the lowest address bit.
		rd_addr = bank_reg(q.bank, {2'b00, RES_ADDR_I[0]});

		if (SFR_WE_I && SFR_ADDR_I == SFR_CLKCTL)
		begin
			d.stretch = SFR_WDATA_I[CLKCTL_MD_HI:0];
		end
		if (SFR_WE_I && SFR_ADDR_I == SFR_PSW)
		begin
			d.bank = SFR_WDATA_I[PSW_RS_HI:PSW_RS_LO];
		end

		// The phase restarts at each accept so every instruction cycle is whole.
		if (accept)
		begin
			d.busy = 1'b1;
			d.phase = 2'd0;
			d.dec = decode(OPCODE_I, q.stretch);
			d.left = d.dec.cycles;
			d.reg_addr = bank_reg(q.bank, d.dec.ptr_op ? {2'b00, OPCODE_I[0]} : OPCODE_I[2:0]);
			d.opnd1 = PC_I + 16'h0001;
			d.opnd2 = PC_I + 16'h0002;
		end
		else if (q.busy)
		begin
			d.phase = q.phase + 2'd1;
			if (q.phase == 2'(CLK_PER_ICYC - 1))
			begin
				d.icyc = 1'b1;
				d.left = q.left - 4'd1;
				if (q.left == 4'd1)
				begin
					d.busy = 1'b0;
					d.done = 1'b1;
				end
			end
		end

		d.onchip = (XADDR_I <= ONCHIP_TOP);

		case (q.rstate)
			RS_IDLE:
			begin
				if (RES_REQ_I && RES_MODE_I == MODE_INDIRECT)
				begin
					rd_en = 1'b1;
					d.rstate = RS_WAIT;
				end
				else if (RES_REQ_I)
				begin
					d.res_valid = 1'b1;
					d.res_bit = 3'd0;
					d.res_addr = RES_ADDR_I;
					d.bitable = 1'b1;
					d.space = SP_LOWER;
					case (mcdec_mode_t'(RES_MODE_I))
						MODE_BIT:
						begin
							if (RES_ADDR_I <= LOWER_TOP)
							begin
								d.res_addr = BITRAM_BASE + {4'h0, RES_ADDR_I[6:3]};
							end
							else
							begin
								d.res_addr = {RES_ADDR_I[7:3], 3'b000};
								d.space = SP_SFR;
							end
							d.res_bit = RES_ADDR_I[2:0];
						end
						MODE_BANK_REG:
						begin
							d.res_addr = bank_reg(q.bank, RES_ADDR_I[2:0]);
							d.bitable = 1'b0;
						end
						default:
						begin
							// Direct: upper half is the special register space.
							if (RES_ADDR_I > LOWER_TOP)
							begin
								d.space = SP_SFR;
								d.bitable = (RES_ADDR_I[2:0] == 3'b000);
							end
							else
							begin
								d.bitable = (RES_ADDR_I[7:4] == BITRAM_BASE[7:4]
									|| RES_ADDR_I[7:4] == 4'h2 + 4'h0);
							end
						end
					endcase
				end
			end
			RS_WAIT:
			begin
				d.rstate = RS_PTR;
			end
			RS_PTR:
			begin
				// Indirect reaches lower RAM or the separate upper RAM, never registers.
				d.res_valid = 1'b1;
				d.res_addr = rd_data;
				d.res_bit = 3'd0;
				d.bitable = 1'b0;
				d.space = (rd_data > LOWER_TOP) ? SP_UPPER : SP_LOWER;
				d.rstate = RS_IDLE;
			end
			default:
			begin
				d.rstate = RS_IDLE;
			end
		endcase
	end

	always_ff @(posedge CLK_I or posedge RST_I)
	begin
		if (RST_I)
		begin
			q <= '0;
			q.stretch <= STRETCH_RST;
			q.bank <= BANK_RST;
			q.rstate <= RS_IDLE;
			q.space <= SP_NONE;
		end
		else
		begin
			q <= d;
		end
	end

	// ==========================================================
	// Outputs
	// ==========================================================
	assign BUSY_O = q.busy;
	assign DONE_O = q.done;
	assign ICYC_O = q.icyc;
	assign DEC_CLASS_O = q.dec.cls;
	assign DEC_BYTES_O = q.dec.bytes;
	assign DEC_CYCLES_O = q.dec.cycles;
	assign DEC_KNOWN_O = q.dec.known;
	assign DEC_REG_ADDR_O = q.reg_addr;
	assign OPND1_ADDR_O = q.opnd1;
	assign OPND2_ADDR_O = q.opnd2;
	assign STRETCH_O = q.stretch;
	assign BANK_O = q.bank;
	assign RES_VALID_O = q.res_valid;
	assign RES_SPACE_O = q.space;
	assign RES_ADDR_O = q.res_addr;
	assign RES_BIT_O = q.res_bit;
	assign RES_BITABLE_O = q.bitable;
	assign ONCHIP_O = q.onchip;

	// ==========================================================
	// Assertions
	// ==========================================================
	logic [5:0] clk_cnt;

	always_ff @(posedge CLK_I or posedge RST_I)
	begin
		if (RST_I)
		begin
			clk_cnt <= 6'd0;
		end
		else if (accept)
		begin
			// The accept edge is clock zero, so DONE_O lands on a count of four per cycle.
			clk_cnt <= 6'd0;
		end
		else if (q.busy)
		begin
			clk_cnt <= clk_cnt + 6'd1;
		end
	end

	default clocking cb @(posedge CLK_I); endclocking
	default disable iff (RST_I);

	sequence s_ind_req;
		q.rstate == RS_IDLE && RES_REQ_I && RES_MODE_I == MODE_INDIRECT;
	endsequence

	sequence s_ind_answer;
		!RES_VALID_O [*2] ##1 RES_VALID_O && RES_SPACE_O != SP_SFR;
	endsequence

	a_icyc_length: assert property (DONE_O |-> clk_cnt == {DEC_CYCLES_O, 2'b00})
		else $error("instruction length not four clocks per cycle");
	a_add_decode: assert property (accept && OPCODE_I[7:3] == OPH_ADD_REG |=>
		DEC_CLASS_O == CLS_ADD_REG && DEC_CYCLES_O == 4'd1
		&& DEC_REG_ADDR_O == {3'b000, $past(BANK_O), $past(OPCODE_I[2:0])})
		else $error("bank register add decoded wrongly");
	a_xdata_stretch: assert property (accept && OPCODE_I == OPC_XDATA_RD_D |=>
		DEC_CYCLES_O == 4'd2 + {1'b0, $past(STRETCH_O)})
		else $error("external move cycles do not follow stretch");
	a_stretch_write: assert property (SFR_WE_I && SFR_ADDR_I == SFR_CLKCTL |=>
		STRETCH_O == $past(SFR_WDATA_I[2:0]))
		else $error("stretch value not taken from clock control");
	a_direct_space: assert property (q.rstate == RS_IDLE && RES_REQ_I
		&& RES_MODE_I == MODE_DIRECT |=> RES_VALID_O
		&& RES_SPACE_O == ($past(RES_ADDR_I) > 8'h7F ? SP_SFR : SP_LOWER))
		else $error("direct address resolved to wrong space");
	a_sfr_bitable: assert property (RES_VALID_O && RES_SPACE_O == SP_SFR
		&& $past(RES_MODE_I) == MODE_DIRECT |-> RES_BITABLE_O == (RES_ADDR_O[2:0] == 3'b000))
		else $error("special register bit capability wrong");
	a_bit_map: assert property (q.rstate == RS_IDLE && RES_REQ_I && RES_MODE_I == MODE_BIT
		&& RES_ADDR_I < 8'h80 |=> RES_ADDR_O == 8'h20 + {4'h0, $past(RES_ADDR_I[6:3])})
		else $error("bit address mapped to wrong byte");
	a_ptr_indirect: assert property (s_ind_req |-> ##1 s_ind_answer)
		else $error("indirect resolution not answered in three cycles");
	a_nop_alias: assert property (accept && OPCODE_I == OPC_RSVD_NOP |=>
		DEC_CLASS_O == CLS_NO_OPERATION && DEC_CYCLES_O == 4'd1)
		else $error("reserved opcode not a no-operation");
	a_operand_order: assert property (accept |=> OPND2_ADDR_O == OPND1_ADDR_O + 16'h0001
		&& OPND1_ADDR_O == $past(PC_I) + 16'h0001)
		else $error("operand addresses not consecutive");
	a_done_pulse: assert property (DONE_O |=> !DONE_O)
		else $error("done held longer than one clock");

endmodule

//--- design/mcdec_iram.sv
// Internal scratch RAM, 256 bytes, one write port and one registered read port.
// Assumes the owner serialises accesses; a read of a word being written returns old data.
`timescale 1ns/1ps
module mcdec_iram #(
	parameter int WIDTH = 8,
	parameter int DEPTH = 256
) (
	input  wire logic                     clk_i,
	input  wire logic                     we_i,
	input  wire logic [$clog2(DEPTH)-1:0] waddr_i,
	input  wire logic [WIDTH-1:0]         wdata_i,
	input  wire logic                     re_i,
	input  wire logic [$clog2(DEPTH)-1:0] raddr_i,
	output logic      [WIDTH-1:0]         rdata_o
);

	// ==========================================================
	// Storage
	// ==========================================================
	logic [WIDTH-1:0] mem [DEPTH];

	if (DEPTH < 2 || WIDTH < 1)
	begin : g_bad
		$error("mcdec_iram: unsupported geometry");
	end

	// No reset on the array keeps it mappable to block RAM.
	always_ff @(posedge clk_i)
	begin
		if (we_i)
		begin
			mem[waddr_i] <= wdata_i;
		end
		if (re_i)
		begin
			rdata_o <= mem[raddr_i];
		end
	end

endmodule

//--- design/mcdec_pkg.sv
// Constants, types and encodings shared by the decode and memory map block.
// Assumes a single 25 MHz clock and an asynchronous active-high reset.
package mcdec_pkg;

	// ==========================================================
	// Timing
	// ==========================================================
	localparam int          CLK_PER_ICYC    = 4;
	localparam logic [3:0]  XDATA_BASE_CYC  = 4'h2;

	// ==========================================================
	// Internal address map
	// ==========================================================
	localparam logic [7:0]  LOWER_TOP       = 8'h7F;
	localparam logic [7:0]  BITRAM_BASE     = 8'h20;
	localparam logic [7:0]  SFR_CLKCTL      = 8'h8E;
	localparam logic [7:0]  SFR_PSW         = 8'hD0;
	localparam int          PSW_RS_LO       = 3;
	localparam int          PSW_RS_HI       = 4;
	localparam int          CLKCTL_MD_HI    = 2;
	localparam logic [2:0]  STRETCH_RST     = 3'h1;
	localparam logic [1:0]  BANK_RST        = 2'h0;
	localparam logic [15:0] ONCHIP_TOP      = 16'h1B3F;

	// ==========================================================
	// Opcodes
	// ==========================================================
	localparam logic [7:0]  OPC_NOP         = 8'h00;
	localparam logic [7:0]  OPC_RSVD_NOP    = 8'hA5;
	localparam logic [4:0]  OPH_ADD_REG     = 5'h05;
	localparam logic [4:0]  OPH_ADD_WITH_CARRY_REG    = 5'h07;
	localparam logic [4:0]  OPH_SUBTRACT_WITH_BORROW_REG    = 5'h13;
	localparam logic [4:0]  OPH_COMPARE_JUMP_UNEQUAL_REG    = 5'h17;
	localparam logic [4:0]  OPH_DECREMENT_JUMP_NONZERO_REG    = 5'h1B;
	localparam logic [6:0]  OPH_XDATA_RD_I  = 7'h71;
	localparam logic [6:0]  OPH_XDATA_WR_I  = 7'h79;
	localparam logic [6:0]  OPH_EXCHANGE_LOW_NIBBLE        = 7'h6B;
	localparam logic [7:0]  OPC_XDATA_RD_D  = 8'hE0;
	localparam logic [7:0]  OPC_XDATA_WR_D  = 8'hF0;
	localparam logic [7:0]  OPC_CODE_DATA_POINTER_REG   = 8'h93;
	localparam logic [7:0]  OPC_CODE_PC     = 8'h83;
	localparam logic [7:0]  OPC_AND_DIR_IMM = 8'h53;
	localparam logic [7:0]  OPC_OR_DIR_IMM  = 8'h43;
	localparam logic [7:0]  OPC_XOR_DIR_IMM = 8'h63;
	localparam logic [7:0]  OPC_MOV_DIR_DIR = 8'h85;
	localparam logic [7:0]  OPC_OR_C_BIT    = 8'h72;
	localparam logic [7:0]  OPC_OR_C_NBIT   = 8'hA0;
	localparam logic [7:0]  OPC_LONG_CALL   = 8'h12;
	localparam logic [7:0]  OPC_RETURN      = 8'h22;
	localparam logic [7:0]  OPC_INT_RETURN  = 8'h32;
	localparam logic [7:0]  OPC_JUMP_BIT_CLR = 8'h10;
	localparam logic [7:0]  OPC_JMP_IND     = 8'h73;
	localparam logic [7:0]  OPC_SHORT_JUMP  = 8'h80;

	// ==========================================================
	// Types
	// ==========================================================
	typedef enum logic [4:0] {
		CLS_NO_OPERATION   = 5'b00000,
		CLS_ADD_REG        = 5'b00001,
		CLS_ADD_WITH_CARRY = 5'b00010,
		CLS_SUB_WITH_BORROW = 5'b00011,
		CLS_EXT_DATA_MOVE  = 5'b00100,
		CLS_CODE_BYTE_MOVE = 5'b00101,
		CLS_LOGIC_DIR_IMM  = 5'b00110,
		CLS_MOV_DIR_DIR    = 5'b00111,
		CLS_OR_C_BIT       = 5'b01000,
		CLS_OR_C_NBIT      = 5'b01001,
		CLS_LONG_CALL      = 5'b01010,
		CLS_RETURN         = 5'b01011,
		CLS_INT_RETURN     = 5'b01100,
		CLS_JUMP_BIT_CLEAR = 5'b01101,
		CLS_CMP_JUMP_UNEQ  = 5'b01110,
		CLS_DEC_JUMP_NZ    = 5'b01111,
		CLS_JUMP_INDIRECT  = 5'b10000,
		CLS_XCH_LOW_NIBBLE = 5'b10001,
		CLS_SHORT_JUMP     = 5'b10010,
		CLS_OTHER          = 5'b10011
	} mcdec_cls_t;

	typedef enum logic [1:0] {
		SP_LOWER = 2'b00,
		SP_UPPER = 2'b01,
		SP_SFR   = 2'b10,
		SP_NONE  = 2'b11
	} mcdec_space_t;

	typedef enum logic [1:0] {
		MODE_DIRECT   = 2'b00,
		MODE_INDIRECT = 2'b01,
		MODE_BIT      = 2'b10,
		MODE_BANK_REG = 2'b11
	} mcdec_mode_t;

	typedef enum logic [1:0] {
		RS_IDLE = 2'b00,
		RS_WAIT = 2'b01,
		RS_PTR  = 2'b10
	} mcdec_rstate_t;

	typedef struct packed {
		mcdec_cls_t cls;
		logic [1:0] bytes;
		logic [3:0] cycles;
		logic       known;
		logic       ptr_op;
	} mcdec_dec_t;

endpackage

//--- dv/mcdec_core_bench.sv
// Self-checking bench for the opcode decode and internal memory map block.
// Assumes the block's package is compiled first and a single 25 MHz clock.
`timescale 1ns/1ps
`define CHK(n, e, s) begin checks_done++; if ((s) !== (e)) begin fail_count++; \
	$display("MISMATCH %s exp %0h got %0h", n, e, s); end end
module mcdec_core_bench
	import mcdec_pkg::*;
;
	logic        clk = 1'b0, rst = 1'b1, dv = 1'b0, swe = 1'b0, iwe = 1'b0;
	logic        rreq = 1'b0, acc = 1'b0;
	logic [7:0]  op = 8'h00, sa = 8'h00, sd = 8'h00, ia = 8'h00, id = 8'h00, ra = 8'h00;
	logic [15:0] pc = 16'h0000, xreq = 16'h0000, xaddr, o1, o2;
	logic [1:0]  rm = 2'h0, bytes, bank, rspace;
	logic        busy, done, icyc, known, rvalid, rbitable, onchip;
	logic [4:0]  cls;
	logic [3:0]  cycs;
	logic [7:0]  regad, raddr;
	logic [2:0]  stretch, rbit;
	int          fail_count = 0;
	int          checks_done = 0;

	mcdec_core uut (
		.CLK_I(clk), .RST_I(rst), .DEC_VALID_I(dv), .OPCODE_I(op), .PC_I(pc),
		.SFR_WE_I(swe), .SFR_ADDR_I(sa), .SFR_WDATA_I(sd), .IRAM_WE_I(iwe),
		.IRAM_ADDR_I(ia), .IRAM_WDATA_I(id), .RES_REQ_I(rreq), .RES_MODE_I(rm),
		.RES_ADDR_I(ra), .XADDR_I(xaddr), .BUSY_O(busy), .DONE_O(done), .ICYC_O(icyc),
		.DEC_CLASS_O(cls), .DEC_BYTES_O(bytes), .DEC_CYCLES_O(cycs), .DEC_KNOWN_O(known),
		.DEC_REG_ADDR_O(regad), .OPND1_ADDR_O(o1), .OPND2_ADDR_O(o2),
		.STRETCH_O(stretch), .BANK_O(bank), .RES_VALID_O(rvalid), .RES_SPACE_O(rspace),
		.RES_ADDR_O(raddr), .RES_BIT_O(rbit), .RES_BITABLE_O(rbitable), .ONCHIP_O(onchip)
	);

	mcdec_umem_model umem (.clk_i(clk), .acc_i(acc), .addr_i(xreq), .xaddr_o(xaddr));

	// ==========================================================
	// Clock, run end and watchdog
	// ==========================================================
	initial
	begin
		forever #20 clk = ~clk;
	end

	task automatic end_sim();
		$display("Comparisons %0d, mismatches %0d", checks_done, fail_count);
		if (fail_count == 0 && checks_done > 0)
			$display("No errors found");
		else
			$display("Errors were found");
		$finish;
	endtask

	// The whole run needs about 440 clocks; the 20000-clock limit, over forty times that, means a hang.
	initial
	begin
		#(40 * 20000);
		fail_count++;
		end_sim();
	end

	// ==========================================================
	// Bus tasks
	// ==========================================================
	task automatic sfr_wr(input logic [7:0] a, input logic [7:0] d);
		@(posedge clk);
		swe <= 1'b1; sa <= a; sd <= d;
		@(posedge clk);
		swe <= 1'b0;
		#1;
	endtask

	task automatic iram_wr(input logic [7:0] a, input logic [7:0] d);
		@(posedge clk);
		iwe <= 1'b1; ia <= a; id <= d;
		@(posedge clk);
		iwe <= 1'b0;
	endtask

	// Decodes one opcode, then counts clocks and cycle pulses up to completion.
	task automatic dec(input logic [7:0] o, input logic [4:0] c, input logic [1:0] b,
		input logic [3:0] n, input logic [7:0] rexp);
		int k;
		int ic;
		k = 0;
		ic = 0;
		@(posedge clk);
		dv <= 1'b1; op <= o; pc <= {8'hC3, o};
		@(posedge clk);
		dv <= 1'b0;
		#1;
		`CHK("busy", 1'b1, busy)
		`CHK("class", c, cls)
		`CHK("bytes", b, bytes)
		`CHK("cycles", n, cycs)
		`CHK("known", (c != CLS_OTHER), known)
		`CHK("operand1", pc + 16'h0001, o1)
		`CHK("operand2", pc + 16'h0002, o2)
		if (rexp != 8'hFF)
			`CHK("regaddr", rexp, regad)
		while (done !== 1'b1 && k < 50)
		begin
			@(posedge clk);
			#1;
			k++;
			ic += int'(icyc);
		end
		`CHK("clocks", 4 * int'(n), k)
		`CHK("icycles", int'(n), ic)
	endtask

	task automatic res(input logic [1:0] m, input logic [7:0] a, input logic [1:0] sp,
		input logic [7:0] ad, input logic [2:0] bt, input logic bl, input int lat);
		int k;
		k = 0;
		@(posedge clk);
		rreq <= 1'b1; rm <= m; ra <= a;
		@(posedge clk);
		rreq <= 1'b0;
		#1;
		while (rvalid !== 1'b1 && k < 8)
		begin
			@(posedge clk);
			#1;
			k++;
		end
		`CHK("latency", lat - 1, k)
		`CHK("space", sp, rspace)
		`CHK("address", ad, raddr)
		if (m == MODE_BIT)
			`CHK("bit", bt, rbit)
		if (m == MODE_DIRECT)
			`CHK("bitable", bl, rbitable)
	endtask

	task automatic onc(input logic [15:0] a, input logic e);
		@(posedge clk);
		acc <= 1'b1; xreq <= a;
		@(posedge clk);
		@(posedge clk);
		#1;
		`CHK("onchip", e, onchip)
		@(posedge clk);
		acc <= 1'b0;
	endtask

	// ==========================================================
	// Scenarios
	// ==========================================================
	initial
	begin
		repeat (6) @(posedge clk);
		rst <= 1'b0;
		#1;
		`CHK("stretch", 3'h1, stretch)
		`CHK("space", 2'h3, rspace)
		dec(8'h28, CLS_ADD_REG, 2'h1, 4'h1, 8'h00);
		dec(8'h3F, CLS_ADD_WITH_CARRY, 2'h1, 4'h1, 8'h07);
		dec(8'h9C, CLS_SUB_WITH_BORROW, 2'h1, 4'h1, 8'h04);
		dec(8'h93, CLS_CODE_BYTE_MOVE, 2'h1, 4'h3, 8'hFF);
		dec(8'h83, CLS_CODE_BYTE_MOVE, 2'h1, 4'h3, 8'hFF);
		dec(8'h53, CLS_LOGIC_DIR_IMM, 2'h3, 4'h3, 8'hFF);
		dec(8'h43, CLS_LOGIC_DIR_IMM, 2'h3, 4'h3, 8'hFF);
		dec(8'h63, CLS_LOGIC_DIR_IMM, 2'h3, 4'h3, 8'hFF);
		dec(8'h85, CLS_MOV_DIR_DIR, 2'h3, 4'h3, 8'hFF);
		dec(8'h72, CLS_OR_C_BIT, 2'h2, 4'h2, 8'hFF);
		dec(8'hA0, CLS_OR_C_NBIT, 2'h2, 4'h2, 8'hFF);
		dec(8'h12, CLS_LONG_CALL, 2'h3, 4'h4, 8'hFF);
		dec(8'h22, CLS_RETURN, 2'h1, 4'h4, 8'hFF);
		dec(8'h32, CLS_INT_RETURN, 2'h1, 4'h4, 8'hFF);
		dec(8'h10, CLS_JUMP_BIT_CLEAR, 2'h3, 4'h4, 8'hFF);
		dec(8'h73, CLS_JUMP_INDIRECT, 2'h1, 4'h3, 8'hFF);
		dec(8'h00, CLS_NO_OPERATION, 2'h1, 4'h1, 8'hFF);
		dec(8'hA5, CLS_NO_OPERATION, 2'h1, 4'h1, 8'hFF);
		dec(8'h80, CLS_SHORT_JUMP, 2'h2, 4'h3, 8'hFF);
		dec(8'h74, CLS_OTHER, 2'h1, 4'h1, 8'hFF);
		dec(8'hE0, CLS_EXT_DATA_MOVE, 2'h1, 4'h3, 8'hFF);
		$display("decode table test finished");
		sfr_wr(8'hD0, 8'h18);
		`CHK("bank", 2'h3, bank)
		sfr_wr(8'h8F, 8'h00);
		`CHK("stretch", 3'h1, stretch)
		dec(8'h2D, CLS_ADD_REG, 2'h1, 4'h1, 8'h1D);
		dec(8'hBF, CLS_CMP_JUMP_UNEQ, 2'h3, 4'h4, 8'h1F);
		dec(8'hDB, CLS_DEC_JUMP_NZ, 2'h2, 4'h3, 8'h1B);
		dec(8'hD7, CLS_XCH_LOW_NIBBLE, 2'h1, 4'h1, 8'h19);
		sfr_wr(8'h8E, 8'hF8);
		dec(8'hF2, CLS_EXT_DATA_MOVE, 2'h1, 4'h2, 8'h18);
		sfr_wr(8'h8E, 8'h07);
		dec(8'hF0, CLS_EXT_DATA_MOVE, 2'h1, 4'h9, 8'hFF);
		dec(8'hE3, CLS_EXT_DATA_MOVE, 2'h1, 4'h9, 8'h19);
		$display("bank and stretch test finished");
		res(MODE_DIRECT, 8'h90, SP_SFR, 8'h90, 3'h0, 1'b1, 1);
		res(MODE_DIRECT, 8'h91, SP_SFR, 8'h91, 3'h0, 1'b0, 1);
		res(MODE_DIRECT, 8'h7F, SP_LOWER, 8'h7F, 3'h0, 1'b0, 1);
		res(MODE_DIRECT, 8'h2F, SP_LOWER, 8'h2F, 3'h0, 1'b1, 1);
		res(MODE_BIT, 8'h0B, SP_LOWER, 8'h21, 3'h3, 1'b0, 1);
		res(MODE_BIT, 8'h7F, SP_LOWER, 8'h2F, 3'h7, 1'b0, 1);
		res(MODE_BIT, 8'h8B, SP_SFR, 8'h88, 3'h3, 1'b0, 1);
		res(MODE_BANK_REG, 8'h05, SP_LOWER, 8'h1D, 3'h0, 1'b0, 1);
		iram_wr(8'h19, 8'hA5);
		res(MODE_INDIRECT, 8'h01, SP_UPPER, 8'hA5, 3'h0, 1'b0, 3);
		iram_wr(8'h18, 8'h40);
		res(MODE_INDIRECT, 8'h00, SP_LOWER, 8'h40, 3'h0, 1'b0, 3);
		$display("address resolve test finished");
		onc(16'h1B3F, 1'b1);
		onc(16'h1B40, 1'b0);
		onc(16'h0000, 1'b1);
		$display("memory map test finished");
		end_sim();
	end
endmodule

//--- dv/mcdec_umem_model.sv
// Model of the unified code and external data memory bus that feeds XADDR_I.
// Assumes the bench raises acc_i while it wants an address presented.
`timescale 1ns/1ps
module mcdec_umem_model
(
	input  wire logic        clk_i,
	input  wire logic        acc_i,
	input  wire logic [15:0] addr_i,
	output logic      [15:0] xaddr_o
);
	// Starts at zero so the idle bus never shows an unknown address.
	logic [15:0] last_q = 16'h0000;

	// A released bus alternates the inverse of the last address with that address, so the stale address reappears every other clock.
	always_ff @(posedge clk_i)
		last_q <= xaddr_o;

	// Code fetches and data moves share one address bus into on-chip RAM.
	assign xaddr_o = acc_i ? addr_i : ~last_q;
endmodule
